// ===== src/blerr_pkg.sv
// Constants for the link and secondary bus error reporting block.
// Assumes a single 100 MHz clock and a classic Wishbone register port.
package blerr_pkg;

  // Register byte offsets, one aligned word each
  localparam logic [7:0] ADR_CTRL     = 8'h00;
  localparam logic [7:0] ADR_UNC_STAT = 8'h04;
  localparam logic [7:0] ADR_COR_STAT = 8'h08;
  localparam logic [7:0] ADR_PCI_STAT = 8'h0C;
  localparam logic [7:0] ADR_DEV_STAT = 8'h10;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h14;
  localparam logic [7:0] ADR_SEVERITY = 8'h18;

  // Control register fields
  localparam int CTL_SYSERR_EN = 0;
  localparam int CTL_PERESP_EN = 1;
  localparam int CTL_COR_MSG   = 2;
  localparam int CTL_NF_MSG    = 3;
  localparam int CTL_FTL_MSG   = 4;
  localparam int CTL_W         = 5;
  localparam logic [4:0] CTRL_RST = 5'h00;

  // Uncorrectable status and severity fields
  localparam int UNC_OVF  = 0;
  localparam int UNC_FLOW = 1;
  localparam int UNC_LINK = 2;
  localparam int UNC_UDE  = 3;
  localparam int UNC_PAD  = 4;
  localparam int UNC_W    = 5;
  localparam logic [4:0] SEV_RST = 5'h00;

  // Correctable status fields
  localparam int COR_BTLP  = 0;
  localparam int COR_BDLLP = 1;
  localparam int COR_RNRO  = 2;
  localparam int COR_RTTO  = 3;
  localparam int COR_W     = 4;

  // Bus-side status fields
  localparam int PCI_DPE  = 0;
  localparam int PCI_SSE  = 1;
  localparam int PCI_MDP  = 2;
  localparam int PCI_W    = 3;

  // Device status and interrupt mask fields
  localparam int DEV_COR = 0;
  localparam int DEV_NF  = 1;
  localparam int DEV_FTL = 2;
  localparam int DEV_W   = 3;
  localparam logic [2:0] MASK_RST = 3'h0;

  // Credit limits and minimum initial credits
  localparam logic [7:0]  HDR_CRD_MAX  = 8'h7F;
  localparam logic [11:0] DATA_CRD_MAX = 12'h7FF;
  localparam logic [7:0]  HDR_CRD_MIN  = 8'h01;
  localparam logic [11:0] DATA_CRD_MIN = 12'h008;
  localparam int          FC_TYPES     = 3;

  // Error message codes
  localparam logic [1:0] MSG_COR = 2'h0;
  localparam logic [1:0] MSG_NF  = 2'h1;
  localparam logic [1:0] MSG_FTL = 2'h3;

  // Parity error pin drive length in cycles
  localparam logic [1:0] PERR_LOW_CYC = 2'h2;

  typedef enum logic [2:0] {
    PERR_IDLE = 3'b001,
    PERR_LOW  = 3'b010,
    PERR_PARK = 3'b100
  } blerr_perr_t;

endpackage

// ===== src/blerr_top.sv
// Link, flow-control and secondary bus error detection with status reporting.
// Assumes event inputs are one-cycle pulses from logic on CLK_I; the
// secondary parity pin arrives from the bus and is synchronised here.
//
// The placing of the registers and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module blerr_top (
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  input  wire logic        WE_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  output logic             ACK_O,
  output logic             IRQ_O,
  input  wire logic        RX_OVERFLOW_I,
  input  wire logic        FC_UPDATE_I,
  input  wire logic        FC_INIT_I,
  input  wire logic [1:0]  FC_TYPE_I,
  input  wire logic [7:0]  FC_HDR_CREDIT_I,
  input  wire logic [11:0] FC_DATA_CREDIT_I,
  input  wire logic        ACKNAK_VALID_I,
  input  wire logic [11:0] ACKNAK_SEQ_I,
  input  wire logic [11:0] ACKED_SEQ_I,
  input  wire logic [11:0] NEXT_TX_SEQ_I,
  input  wire logic        TLP_END_I,
  input  wire logic        TLP_EDB_I,
  input  wire logic        TLP_LCRC_OK_I,
  input  wire logic        TLP_LCRC_INV_I,
  input  wire logic        TLP_SEQ_OK_I,
  input  wire logic        DLLP_VALID_I,
  input  wire logic        DLLP_CRC_OK_I,
  input  wire logic        REPLAY_ROLLOVER_I,
  input  wire logic        REPLAY_TIMEOUT_I,
  input  wire logic        PCI_CPL_DATA_ERR_I,
  input  wire logic        NPW_ACTIVE_I,
  input  wire logic        SECONDARY_PARITY_ERROR_PIN_N_I,
  output logic             SECONDARY_PARITY_ERROR_PIN_N_O,
  output logic             SECONDARY_PARITY_ERROR_PIN_N_OE_O,
  output logic             MSG_VALID_O,
  output logic      [1:0]  MSG_TYPE_O
);

  // Modular distance between two sequence numbers
  function automatic logic [11:0] seq_dist(input logic [11:0] a, input logic [11:0] b);
    seq_dist = a - b;
  endfunction

  logic [blerr_pkg::CTL_W-1:0] ctrl_ff;
  logic [blerr_pkg::UNC_W-1:0] unc_ff;
  logic [blerr_pkg::UNC_W-1:0] sev_ff;
  logic [blerr_pkg::COR_W-1:0] cor_ff;
  logic [blerr_pkg::PCI_W-1:0] pci_ff;
  logic [blerr_pkg::DEV_W-1:0] dev_ff;
  logic [blerr_pkg::DEV_W-1:0] mask_ff;
  logic [31:0]                 dat_ff;
  logic                        ack_ff;
  logic [blerr_pkg::FC_TYPES-1:0] inf_hdr_ff;
  logic [blerr_pkg::FC_TYPES-1:0] inf_data_ff;
  logic                        pin_s1_ff;
  logic                        pin_s2_ff;
  logic [1:0]                  drv_hist_ff;
  blerr_pkg::blerr_perr_t      perr_state_ff;
  blerr_pkg::blerr_perr_t      nxt_perr_state;
  logic [1:0]                  perr_cnt_ff;
  logic                        msg_valid_ff;
  logic [1:0]                  msg_type_ff;

  logic                        req;
  logic                        wr;
  logic [7:0]                  wbyte;
  logic [31:0]                 rd_mux;
  logic                        fc_typ_ok;
  logic                        fc_err;
  logic                        seq_err;
  logic                        tlp_bad;
  logic                        perr_seen;
  logic                        perr_start;
  logic [blerr_pkg::UNC_W-1:0] unc_set;
  logic [blerr_pkg::UNC_W-1:0] unc_new;
  logic [blerr_pkg::COR_W-1:0] cor_set;
  logic [blerr_pkg::PCI_W-1:0] pci_set;
  logic [blerr_pkg::DEV_W-1:0] dev_set;
  logic                        ftl_new;
  logic                        nf_new;
  logic                        cor_new;
  logic                        send_ftl;
  logic                        send_nf;
  logic                        send_cor;
  logic                        peresp;

  assign peresp = ctrl_ff[blerr_pkg::CTL_PERESP_EN];

  // Wishbone slave: one wait state, unmapped reads return zero
  assign req   = CYC_I & STB_I & ~ack_ff;
  assign wr    = req & WE_I & SEL_I[0];
  assign wbyte = DAT_I[7:0];

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (ADR_I)
      blerr_pkg::ADR_CTRL:     rd_mux[blerr_pkg::CTL_W-1:0] = ctrl_ff;
      blerr_pkg::ADR_UNC_STAT: rd_mux[blerr_pkg::UNC_W-1:0] = unc_ff;
      blerr_pkg::ADR_COR_STAT: rd_mux[blerr_pkg::COR_W-1:0] = cor_ff;
      blerr_pkg::ADR_PCI_STAT: rd_mux[blerr_pkg::PCI_W-1:0] = pci_ff;
      blerr_pkg::ADR_DEV_STAT: rd_mux[blerr_pkg::DEV_W-1:0] = dev_ff;
      blerr_pkg::ADR_IRQ_MASK: rd_mux[blerr_pkg::DEV_W-1:0] = mask_ff;
      blerr_pkg::ADR_SEVERITY: rd_mux[blerr_pkg::UNC_W-1:0] = sev_ff;
      default:                 rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req;
      if (req) begin
        dat_ff <= rd_mux;
      end
    end
  end

  assign ACK_O = ack_ff;
  assign DAT_O = dat_ff;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_ff <= blerr_pkg::CTRL_RST;
      sev_ff  <= blerr_pkg::SEV_RST;
      mask_ff <= blerr_pkg::MASK_RST;
    end else if (wr) begin
      if (ADR_I == blerr_pkg::ADR_CTRL) begin
        ctrl_ff <= wbyte[blerr_pkg::CTL_W-1:0];
      end
      if (ADR_I == blerr_pkg::ADR_SEVERITY) begin
        sev_ff <= wbyte[blerr_pkg::UNC_W-1:0];
      end
      if (ADR_I == blerr_pkg::ADR_IRQ_MASK) begin
        mask_ff <= wbyte[blerr_pkg::DEV_W-1:0];
      end
    end
  end

  // Infinite credit memory per credit type; zero at init means infinite
  assign fc_typ_ok = FC_TYPE_I < 2'(blerr_pkg::FC_TYPES);

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      inf_hdr_ff  <= '0;
      inf_data_ff <= '0;
    end else if (FC_UPDATE_I & FC_INIT_I & fc_typ_ok) begin
      inf_hdr_ff[FC_TYPE_I]  <= (FC_HDR_CREDIT_I == 8'h00);
      inf_data_ff[FC_TYPE_I] <= (FC_DATA_CREDIT_I == 12'h000);
    end
  end

  always_comb begin
    fc_err = 1'b0;
    if (FC_UPDATE_I) begin
      if (FC_HDR_CREDIT_I > blerr_pkg::HDR_CRD_MAX ||
          FC_DATA_CREDIT_I > blerr_pkg::DATA_CRD_MAX) begin
        fc_err = 1'b1;
      end
      if (FC_INIT_I &&
          ((FC_HDR_CREDIT_I != 8'h00 && FC_HDR_CREDIT_I < blerr_pkg::HDR_CRD_MIN) ||
           (FC_DATA_CREDIT_I != 12'h000 && FC_DATA_CREDIT_I < blerr_pkg::DATA_CRD_MIN))) begin
        fc_err = 1'b1;
      end
      if (!FC_INIT_I && fc_typ_ok &&
          ((inf_hdr_ff[FC_TYPE_I] && FC_HDR_CREDIT_I != 8'h00) ||
           (inf_data_ff[FC_TYPE_I] && FC_DATA_CREDIT_I != 12'h000))) begin
        fc_err = 1'b1;
      end
    end
  end

  assign seq_err = ACKNAK_VALID_I &&
                   (seq_dist(ACKNAK_SEQ_I, ACKED_SEQ_I) >
                    seq_dist(NEXT_TX_SEQ_I - 12'h001, ACKED_SEQ_I));

  assign tlp_bad = TLP_END_I &&
                   (TLP_EDB_I ? !TLP_LCRC_INV_I : (!TLP_LCRC_OK_I || !TLP_SEQ_OK_I));

  // Two-flop synchroniser for the secondary parity pin
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pin_s1_ff <= 1'b1;
      pin_s2_ff <= 1'b1;
    end else begin
      pin_s1_ff <= SECONDARY_PARITY_ERROR_PIN_N_I;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // Own drive is masked for the synchroniser latency to avoid self-detection
  assign perr_seen = NPW_ACTIVE_I && !pin_s2_ff &&
                     perr_state_ff == blerr_pkg::PERR_IDLE && drv_hist_ff == 2'b00;

  always_comb begin
    unc_set = '0;
    cor_set = '0;
    unc_set[blerr_pkg::UNC_OVF]  = RX_OVERFLOW_I;
    unc_set[blerr_pkg::UNC_FLOW] = fc_err;
    unc_set[blerr_pkg::UNC_LINK] = seq_err;
    unc_set[blerr_pkg::UNC_UDE]  = PCI_CPL_DATA_ERR_I;
    unc_set[blerr_pkg::UNC_PAD]  = perr_seen;
    cor_set[blerr_pkg::COR_BTLP]  = tlp_bad;
    cor_set[blerr_pkg::COR_BDLLP] = DLLP_VALID_I & ~DLLP_CRC_OK_I;
    cor_set[blerr_pkg::COR_RNRO]  = REPLAY_ROLLOVER_I;
    cor_set[blerr_pkg::COR_RTTO]  = REPLAY_TIMEOUT_I;
  end

  // only first occurrences send messages or start the pin drive
  assign unc_new = unc_set & ~unc_ff;
  assign ftl_new = |(unc_new & sev_ff);
  assign nf_new  = |(unc_new & ~sev_ff);
  assign cor_new = |(cor_set & ~cor_ff);

  // One message per cycle; the most severe wins
  assign send_ftl = ftl_new & ctrl_ff[blerr_pkg::CTL_FTL_MSG];
  assign send_nf  = !send_ftl & nf_new & ctrl_ff[blerr_pkg::CTL_NF_MSG];
  assign send_cor = !send_ftl & !send_nf & cor_new & ctrl_ff[blerr_pkg::CTL_COR_MSG];

  always_comb begin
    dev_set = '0;
    pci_set = '0;
    dev_set[blerr_pkg::DEV_COR] = |cor_set;
    dev_set[blerr_pkg::DEV_FTL] = |(unc_set & sev_ff);
    dev_set[blerr_pkg::DEV_NF]  = |(unc_set & ~sev_ff);
    pci_set[blerr_pkg::PCI_DPE] = PCI_CPL_DATA_ERR_I;
    pci_set[blerr_pkg::PCI_SSE] = (send_ftl | send_nf) & ctrl_ff[blerr_pkg::CTL_SYSERR_EN];
    pci_set[blerr_pkg::PCI_MDP] = (PCI_CPL_DATA_ERR_I | perr_seen) & peresp;
  end

  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      unc_ff <= '0;
      cor_ff <= '0;
      pci_ff <= '0;
      dev_ff <= '0;
    end else begin
      unc_ff <= (unc_ff & ~((wr && ADR_I == blerr_pkg::ADR_UNC_STAT) ?
                 wbyte[blerr_pkg::UNC_W-1:0] : '0)) | unc_set;
      cor_ff <= (cor_ff & ~((wr && ADR_I == blerr_pkg::ADR_COR_STAT) ?
                 wbyte[blerr_pkg::COR_W-1:0] : '0)) | cor_set;
      pci_ff <= (pci_ff & ~((wr && ADR_I == blerr_pkg::ADR_PCI_STAT) ?
                 wbyte[blerr_pkg::PCI_W-1:0] : '0)) | pci_set;
      dev_ff <= (dev_ff & ~((wr && ADR_I == blerr_pkg::ADR_DEV_STAT) ?
                 wbyte[blerr_pkg::DEV_W-1:0] : '0)) | dev_set;
    end
  end

  assign IRQ_O = |(dev_ff & mask_ff);

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      msg_valid_ff <= 1'b0;
      msg_type_ff  <= blerr_pkg::MSG_COR;
    end else begin
      msg_valid_ff <= send_ftl | send_nf | send_cor;
      if (send_ftl) begin
        msg_type_ff <= blerr_pkg::MSG_FTL;
      end else if (send_nf) begin
        msg_type_ff <= blerr_pkg::MSG_NF;
      end else if (send_cor) begin
        msg_type_ff <= blerr_pkg::MSG_COR;
      end
    end
  end

  assign MSG_VALID_O = msg_valid_ff;
  assign MSG_TYPE_O  = msg_type_ff;

  // pin drive only with response enabled
  assign perr_start = PCI_CPL_DATA_ERR_I & peresp & unc_new[blerr_pkg::UNC_UDE];

  always_comb begin
    nxt_perr_state = perr_state_ff;
    unique case (perr_state_ff)
      blerr_pkg::PERR_IDLE: begin
        if (perr_start) begin
          nxt_perr_state = blerr_pkg::PERR_LOW;
        end
      end
      blerr_pkg::PERR_LOW: begin
        if (perr_cnt_ff == blerr_pkg::PERR_LOW_CYC - 2'h1) begin
          nxt_perr_state = blerr_pkg::PERR_PARK;
        end
      end
      blerr_pkg::PERR_PARK: nxt_perr_state = blerr_pkg::PERR_IDLE;
      default:              nxt_perr_state = blerr_pkg::PERR_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      perr_state_ff <= blerr_pkg::PERR_IDLE;
      perr_cnt_ff   <= 2'h0;
      drv_hist_ff   <= 2'b00;
    end else begin
      perr_state_ff <= nxt_perr_state;
      perr_cnt_ff   <= (perr_state_ff == blerr_pkg::PERR_LOW) ? perr_cnt_ff + 2'h1 : 2'h0;
      drv_hist_ff   <= {drv_hist_ff[0], perr_state_ff != blerr_pkg::PERR_IDLE};
    end
  end

  // Park high one cycle before release so the pull-up is not relied on
  assign SECONDARY_PARITY_ERROR_PIN_N_O  = perr_state_ff != blerr_pkg::PERR_LOW;
  assign SECONDARY_PARITY_ERROR_PIN_N_OE_O = perr_state_ff != blerr_pkg::PERR_IDLE;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_perr_drive;
    (!SECONDARY_PARITY_ERROR_PIN_N_O && SECONDARY_PARITY_ERROR_PIN_N_OE_O) [*2]
    ##1 (SECONDARY_PARITY_ERROR_PIN_N_O && SECONDARY_PARITY_ERROR_PIN_N_OE_O)
    ##1 !SECONDARY_PARITY_ERROR_PIN_N_OE_O;
  endsequence

  sequence s_cpl_err_first;
    PCI_CPL_DATA_ERR_I && !unc_ff[blerr_pkg::UNC_UDE] &&
    perr_state_ff == blerr_pkg::PERR_IDLE;
  endsequence

  AST_OVERFLOW: assert property (RX_OVERFLOW_I |=> unc_ff[blerr_pkg::UNC_OVF] &&
    (dev_ff[blerr_pkg::DEV_FTL] || dev_ff[blerr_pkg::DEV_NF]))
    else $error("Overflow not reported");
  AST_FC_MAX: assert property (FC_UPDATE_I && FC_DATA_CREDIT_I > 12'h7FF
    |=> unc_ff[blerr_pkg::UNC_FLOW]) else $error("Data credit ceiling missed");
  AST_FC_INF: assert property (FC_UPDATE_I && !FC_INIT_I && FC_TYPE_I == 2'h0 &&
    inf_hdr_ff[0] && FC_HDR_CREDIT_I == 8'h01 |=> unc_ff[blerr_pkg::UNC_FLOW])
    else $error("Infinite credit violation missed");
  AST_SEQ: assert property (ACKNAK_VALID_I && ACKNAK_SEQ_I == NEXT_TX_SEQ_I &&
    NEXT_TX_SEQ_I != ACKED_SEQ_I |=> unc_ff[blerr_pkg::UNC_LINK])
    else $error("Bad sequence number not flagged");
  AST_TLP: assert property (TLP_END_I && !TLP_EDB_I && !TLP_LCRC_OK_I
    |=> cor_ff[blerr_pkg::COR_BTLP] && dev_ff[blerr_pkg::DEV_COR])
    else $error("Bad packet not flagged");
  AST_TMO: assert property (REPLAY_TIMEOUT_I |=> cor_ff[blerr_pkg::COR_RTTO])
    else $error("Replay timeout not flagged");
  AST_SSE: assert property ($rose(pci_ff[blerr_pkg::PCI_SSE]) |->
    MSG_VALID_O && MSG_TYPE_O != blerr_pkg::MSG_COR && $past(ctrl_ff[blerr_pkg::CTL_SYSERR_EN]))
    else $error("System error flag without message");
  AST_PERR_ON: assert property (s_cpl_err_first and peresp |=> s_perr_drive)
    else $error("Parity pin sequence wrong");
  AST_PERR_OFF: assert property (s_cpl_err_first and !peresp
    |=> !SECONDARY_PARITY_ERROR_PIN_N_OE_O [*3]) else $error("Parity pin driven while disabled");
  AST_MDP: assert property (PCI_CPL_DATA_ERR_I && !peresp &&
    !pci_ff[blerr_pkg::PCI_MDP] && !perr_seen |=> !pci_ff[blerr_pkg::PCI_MDP])
    else $error("Master parity set while disabled");
  AST_PAD: assert property (perr_seen && peresp |=> unc_ff[blerr_pkg::UNC_PAD] &&
    pci_ff[blerr_pkg::PCI_MDP]) else $error("Target parity not recorded");
  AST_STICKY: assert property (!(wr && ADR_I == blerr_pkg::ADR_COR_STAT)
    |=> (cor_ff & $past(cor_ff)) == $past(cor_ff)) else $error("Sticky flag lost");

endmodule

`default_nettype wire

// ===== bench/blerr_pci_tgt.sv
// Secondary bus target model that pulls the shared parity line low on request.
// Assumes the bench feeds the resolved line back into the bridge.
`timescale 1ns/1ps
`default_nettype none

module blerr_pci_tgt (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic perr_req_i,
  input  wire logic dut_o_i,
  input  wire logic dut_oe_i,
  output logic      pin_n_o
);
  logic [1:0] low_cnt_ff;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_cnt_ff <= 2'h0;
    end else if (perr_req_i) begin
      low_cnt_ff <= 2'h2;
    end else if (low_cnt_ff != 2'h0) begin
      low_cnt_ff <= low_cnt_ff - 2'h1;
    end
  end

  // Pull-up keeps the line high when nobody drives it
  assign pin_n_o = dut_oe_i ? dut_o_i : (low_cnt_ff == 2'h0);
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the bridge error reporting block.
// Assumes the bus target model shares the parity line with the bridge.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        clk;
  logic        rst;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] got;
  logic        we;
  logic        cyc;
  logic        ack;
  logic        irq;
  logic [7:0]  ev;
  logic [5:0]  q;
  logic [1:0]  fct;
  logic [7:0]  hdr;
  logic [11:0] dcr;
  logic [11:0] aseq;
  logic        npw;
  logic        preq;
  logic        pin_n;
  logic        pin_do;
  logic        pin_oe;
  logic        msg_v;
  logic [1:0]  msg_t;
  int          num_errors;
  int          comparisons;

  blerr_top uut (.CLK_I(clk), .RST_I(rst), .ADR_I(adr), .DAT_I(wdat), .DAT_O(rdat),
    .WE_I(we), .SEL_I(4'hF), .CYC_I(cyc), .STB_I(cyc), .ACK_O(ack), .IRQ_O(irq),
    .RX_OVERFLOW_I(ev[0]), .FC_UPDATE_I(ev[1]), .FC_INIT_I(q[5]), .FC_TYPE_I(fct),
    .FC_HDR_CREDIT_I(hdr), .FC_DATA_CREDIT_I(dcr), .ACKNAK_VALID_I(ev[2]),
    .ACKNAK_SEQ_I(aseq), .ACKED_SEQ_I(12'h00A), .NEXT_TX_SEQ_I(12'h014),
    .TLP_END_I(ev[3]), .TLP_EDB_I(q[0]), .TLP_LCRC_OK_I(q[1]), .TLP_LCRC_INV_I(q[2]),
    .TLP_SEQ_OK_I(q[3]), .DLLP_VALID_I(ev[4]), .DLLP_CRC_OK_I(q[4]),
    .REPLAY_ROLLOVER_I(ev[5]), .REPLAY_TIMEOUT_I(ev[6]), .PCI_CPL_DATA_ERR_I(ev[7]),
    .NPW_ACTIVE_I(npw), .SECONDARY_PARITY_ERROR_PIN_N_I(pin_n),
    .SECONDARY_PARITY_ERROR_PIN_N_O(pin_do), .SECONDARY_PARITY_ERROR_PIN_N_OE_O(pin_oe),
    .MSG_VALID_O(msg_v), .MSG_TYPE_O(msg_t));

  blerr_pci_tgt tgt (.clk_i(clk), .rst_i(rst), .perr_req_i(preq), .dut_o_i(pin_do),
    .dut_oe_i(pin_oe), .pin_n_o(pin_n));

  task automatic complete_run();
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Held until the acking edge; one idle cycle follows
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    we <= w;
    wdat <= d;
    cyc <= 1'b1;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    got = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(a, 1'b0, 32'h0000_0000);
    chk(got, e);
  endtask

  task automatic clr();
    for (int i = 1; i < 5; i++) begin
      wb(8'(i * 4), 1'b1, 32'h0000_00FF);
    end
  endtask

  task automatic pulse(input int n, input logic [5:0] qv, input logic v, input logic [1:0] t);
    @(posedge clk);
    ev[n] <= 1'b1;
    q <= qv;
    @(posedge clk);
    ev[n] <= 1'b0;
    #1;
    chk({31'h0, msg_v}, {31'h0, v});
    if (v) chk({30'h0, msg_t}, {30'h0, t});
  endtask

  task automatic fields(input logic [7:0] h, input logic [11:0] d, input logic [11:0] s);
    @(posedge clk);
    hdr <= h;
    dcr <= d;
    aseq <= s;
  endtask

  // Message expected exactly when a fresh flag is expected
  task automatic ev_chk(input int n, input logic [5:0] qv, input logic [1:0] t,
                        input logic [7:0] a, input logic [31:0] e);
    pulse(n, qv, e != 32'h0000_0000, t);
    rd_chk(a, e);
    clr();
  endtask

  task automatic t_reset();
    wb(8'h1C, 1'b1, 32'h0000_00FF);
    for (int a = 0; a < 8; a++) begin
      rd_chk(8'(a * 4), 32'h0000_0000);
    end
    chk({31'h0, irq}, 32'h0000_0000);
  endtask

  task automatic t_rxo();
    wb(blerr_pkg::ADR_SEVERITY, 1'b1, 32'h0000_0001);
    wb(blerr_pkg::ADR_CTRL, 1'b1, 32'h0000_001F);
    pulse(0, 6'h00, 1'b1, blerr_pkg::MSG_FTL);
    rd_chk(blerr_pkg::ADR_UNC_STAT, 32'h0000_0001);
    rd_chk(blerr_pkg::ADR_DEV_STAT, 32'h0000_0004);
    rd_chk(blerr_pkg::ADR_PCI_STAT, 32'h0000_0002);
    pulse(0, 6'h00, 1'b0, 2'h0);
    chk({31'h0, irq}, 32'h0000_0000);
    wb(blerr_pkg::ADR_IRQ_MASK, 1'b1, 32'h0000_0004);
    chk({31'h0, irq}, 32'h0000_0001);
    clr();
    chk({31'h0, irq}, 32'h0000_0000);
    rd_chk(blerr_pkg::ADR_UNC_STAT, 32'h0000_0000);
    wb(blerr_pkg::ADR_CTRL, 1'b1, 32'h0000_001E);
    pulse(0, 6'h00, 1'b1, blerr_pkg::MSG_FTL);
    rd_chk(blerr_pkg::ADR_PCI_STAT, 32'h0000_0000);
    clr();
    wb(blerr_pkg::ADR_SEVERITY, 1'b1, 32'h0000_0000);
    wb(blerr_pkg::ADR_CTRL, 1'b1, 32'h0000_001F);
  endtask

  task automatic t_link();
    fields(8'h7F, 12'h7FF, 12'h00F);
    ev_chk(1, 6'h00, blerr_pkg::MSG_NF, blerr_pkg::ADR_UNC_STAT, 32'h0000_0000);
    fields(8'h80, 12'h001, 12'h013);
    ev_chk(1, 6'h00, blerr_pkg::MSG_NF, blerr_pkg::ADR_UNC_STAT, 32'h0000_0002);
    fields(8'h01, 12'h800, 12'h014);
    ev_chk(1, 6'h00, blerr_pkg::MSG_NF, blerr_pkg::ADR_UNC_STAT, 32'h0000_0002);
    ev_chk(2, 6'h00, blerr_pkg::MSG_NF, blerr_pkg::ADR_UNC_STAT, 32'h0000_0004);
    fields(8'h01, 12'h004, 12'h013);
    ev_chk(1, 6'h20, blerr_pkg::MSG_NF, blerr_pkg::ADR_UNC_STAT, 32'h0000_0002);
    fields(8'h00, 12'h000, 12'h013);
    ev_chk(1, 6'h20, blerr_pkg::MSG_NF, blerr_pkg::ADR_UNC_STAT, 32'h0000_0000);
    ev_chk(2, 6'h00, blerr_pkg::MSG_NF, blerr_pkg::ADR_UNC_STAT, 32'h0000_0000);
    fields(8'h01, 12'h000, 12'h009);
    ev_chk(1, 6'h00, blerr_pkg::MSG_NF, blerr_pkg::ADR_UNC_STAT, 32'h0000_0002);
    ev_chk(2, 6'h00, blerr_pkg::MSG_NF, blerr_pkg::ADR_UNC_STAT, 32'h0000_0004);
  endtask

  task automatic t_cor();
    ev_chk(3, 6'h01, blerr_pkg::MSG_COR, blerr_pkg::ADR_COR_STAT, 32'h0000_0001);
    ev_chk(3, 6'h05, blerr_pkg::MSG_COR, blerr_pkg::ADR_COR_STAT, 32'h0000_0000);
    ev_chk(3, 6'h08, blerr_pkg::MSG_COR, blerr_pkg::ADR_COR_STAT, 32'h0000_0001);
    ev_chk(3, 6'h02, blerr_pkg::MSG_COR, blerr_pkg::ADR_COR_STAT, 32'h0000_0001);
    ev_chk(3, 6'h0A, blerr_pkg::MSG_COR, blerr_pkg::ADR_COR_STAT, 32'h0000_0000);
    ev_chk(4, 6'h00, blerr_pkg::MSG_COR, blerr_pkg::ADR_COR_STAT, 32'h0000_0002);
    ev_chk(4, 6'h10, blerr_pkg::MSG_COR, blerr_pkg::ADR_COR_STAT, 32'h0000_0000);
    ev_chk(5, 6'h00, blerr_pkg::MSG_COR, blerr_pkg::ADR_COR_STAT, 32'h0000_0004);
    pulse(6, 6'h00, 1'b1, blerr_pkg::MSG_COR);
    rd_chk(blerr_pkg::ADR_COR_STAT, 32'h0000_0008);
    rd_chk(blerr_pkg::ADR_DEV_STAT, 32'h0000_0001);
    rd_chk(blerr_pkg::ADR_PCI_STAT, 32'h0000_0000);
    clr();
  endtask

  task automatic t_cpl(input logic [31:0] c, input logic d, input logic [31:0] p);
    wb(blerr_pkg::ADR_CTRL, 1'b1, c);
    pulse(7, 6'h00, 1'b1, blerr_pkg::MSG_NF);
    chk({30'h0, pin_oe, pin_do}, {30'h0, d, !d});
    @(posedge clk);
    #1;
    chk({30'h0, pin_oe, pin_do}, {30'h0, d, !d});
    @(posedge clk);
    #1;
    chk({30'h0, pin_oe, pin_do}, {30'h0, d, 1'b1});
    @(posedge clk);
    #1;
    chk({31'h0, pin_oe}, 32'h0000_0000);
    rd_chk(blerr_pkg::ADR_UNC_STAT, 32'h0000_0008);
    rd_chk(blerr_pkg::ADR_PCI_STAT, p);
    rd_chk(blerr_pkg::ADR_DEV_STAT, 32'h0000_0002);
    clr();
  endtask

  task automatic t_npw(input logic [31:0] c, input logic [31:0] p);
    wb(blerr_pkg::ADR_CTRL, 1'b1, c);
    @(posedge clk);
    npw <= 1'b1;
    preq <= 1'b1;
    @(posedge clk);
    preq <= 1'b0;
    repeat (4) @(posedge clk);
    npw <= 1'b0;
    rd_chk(blerr_pkg::ADR_UNC_STAT, 32'h0000_0010);
    rd_chk(blerr_pkg::ADR_PCI_STAT, p);
    rd_chk(blerr_pkg::ADR_DEV_STAT, 32'h0000_0002);
    clr();
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole sequence needs a few hundred cycles
  initial begin
    #100000;
    num_errors++;
    complete_run();
  end

  initial begin
    num_errors = 0;
    comparisons = 0;
    rst = 1'b1;
    {adr, wdat, we, cyc, ev, q, hdr, dcr, aseq, npw, preq} = '0;
    fct = 2'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_rxo();
    t_link();
    t_cor();
    t_cpl(32'h0000_001F, 1'b1, 32'h0000_0007);
    t_cpl(32'h0000_001D, 1'b0, 32'h0000_0003);
    t_npw(32'h0000_001F, 32'h0000_0006);
    t_npw(32'h0000_001D, 32'h0000_0002);
    complete_run();
  end
endmodule
`default_nettype wire
